// [hdl/csc_pkg.sv]
// Purpose: Shared constants and types for the codec secondary command registers.
// Assumes: Byte-wide register port with 16-bit addresses.
// Notes: Offsets are the absolute register addresses of the host controller map.
package csc_pkg;

  // --------------------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------------------
  localparam int CSC_ADDR_W = 16;
  localparam int CSC_DATA_W = 8;
  localparam logic [15:0] CSC_OFF_VALID_SLOT_LOW = 16'hffd8;
  localparam logic [15:0] CSC_OFF_COMMAND_DATA_HIGH = 16'hffd9;
  localparam logic [15:0] CSC_OFF_COMMAND_DATA_LOW = 16'hffda;
  localparam logic [15:0] CSC_OFF_COMMAND_ADDRESS = 16'hffdb;

  // --------------------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------------------
  localparam logic [7:0] CSC_RST_VALID_SLOT_LOW = 8'h00;
  localparam logic [7:0] CSC_RST_COMMAND_DATA_HIGH = 8'h00;
  localparam logic [7:0] CSC_RST_COMMAND_DATA_LOW = 8'h00;
  localparam logic [7:0] CSC_RST_COMMAND_ADDRESS = 8'h00;

  // --------------------------------------------------------------------------
  // Field layout
  // --------------------------------------------------------------------------
  localparam int CSC_RW_BIT = 7;
  localparam int CSC_AC97_ADDR_MSB = 6;
  localparam int CSC_SLOT_FLAG_MSB = 7;
  localparam int CSC_SLOT_FLAG_LSB = 3;
  localparam int CSC_SLOT_FLAG_W = 5;
  localparam logic [2:0] CSC_RESERVED_READ = 3'h0;
  localparam logic [1:0] CSC_CID_PRIMARY = 2'h0;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    CSC_MODE_AC97,
    CSC_MODE_AC97_DUAL,
    CSC_MODE_GENERAL,
    CSC_MODE_SHORT_FRAME,
    CSC_MODE_I2S
  } csc_mode_type;

  typedef enum logic [1:0] {
    CSC_ST_IDLE,
    CSC_ST_WRITE,
    CSC_ST_READ_WAIT
  } csc_txn_state_type;

  // Tells whether a port mode is one of the AC '97 modes.
  function automatic logic csc_is_ac97(input csc_mode_type mode);
    logic result;
    result = (mode == CSC_MODE_AC97) || (mode == CSC_MODE_AC97_DUAL);
    return result;
  endfunction

endpackage

// [hdl/csc_regs.sv]
// Purpose: Secondary command/status registers of the serial codec port.
// Assumes: Serializer and deserializer run on sys_clk_i and give one-cycle strobes.
// Notes: Register port is byte wide; read data appear one cycle after the strobe.
// How it works
// - Write sends all eight address bits.
// - Select bit one reads, zero writes.
// - Read overwrites address (bits 6..0 only in AC97 modes) with codec's returned address.
// - Sixteen-bit data split low and high bytes.
// - Read replaces data bytes with codec status.
// - Non-AC97 modes use low byte only.
// - Flag bits 7..3 mark slots 8..12 valid.
// - Slot flags apply only in AC97 modes.
// - Reserved bits read zero; everything resets zero.
// - Codec select 00 primary, else secondary.
`timescale 1ns/1ps
`default_nettype none
module csc_regs
  import csc_pkg::*;
(
  input wire logic sys_clk_i, // System clock, 25 MHz.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic [15:0] reg_addr_i, // Register address.
  input wire logic [7:0] reg_wdata_i, // Register write data.
  input wire logic reg_wr_i, // Write strobe.
  input wire logic reg_rd_i, // Read strobe.
  output logic [7:0] reg_rdata_o, // Read data, one cycle after the strobe.
  input wire csc_pkg::csc_mode_type port_mode_i, // Codec port mode.
  input wire logic [1:0] codec_select_field_i, // Target codec of the transaction.
  input wire logic cmd_issue_i, // Serializer takes the command into a frame.
  input wire logic tx_frame_end_i, // Outgoing frame has been sent.
  input wire logic rx_frame_start_i, // Incoming frame begins.
  input wire logic rx_addr_stb_i, // Returned address valid.
  input wire logic [7:0] rx_addr_i, // Returned address.
  input wire logic rx_data_stb_i, // Returned status data valid.
  input wire logic [15:0] rx_data_i, // Returned status data.
  input wire logic rx_frame_end_i, // Incoming frame fully received.
  output logic [7:0] tx_address_o, // Command address for the frame.
  output logic [15:0] tx_data_o, // Command data for the frame.
  output logic [1:0] tx_codec_id_o, // Codec identifier for the frame.
  output logic tx_is_read_o, // Transaction in flight is a read.
  output logic [4:0] slot_valid_flags_o, // Valid flags for slots 8 to 12.
  output logic busy_o, // A secondary transaction is in flight.
  output logic read_done_o // Read results committed, one-cycle pulse.
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic [4:0] slot_flags;
  logic [7:0] command_data_high;
  logic [7:0] command_data_low;
  logic [7:0] command_address;
  logic [4:0] next_slot_flags;
  logic [7:0] next_command_data_high;
  logic [7:0] next_command_data_low;
  logic [7:0] next_command_address;
  logic [7:0] next_reg_rdata;
  csc_txn_state_type state;
  csc_txn_state_type next_state;
  logic txn_is_read;
  logic next_txn_is_read;
  logic txn_ac97;
  logic next_txn_ac97;
  logic next_read_done;
  logic commit;
  logic [7:0] shadow_addr;
  logic [15:0] shadow_data;
  logic shadow_full;
  logic hit_slot;
  logic hit_high;
  logic hit_low;
  logic hit_addr;

  // --------------------------------------------------------------------------
  // Outgoing command
  // --------------------------------------------------------------------------
  csc_tx_format u_tx_format
  (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .load_i(cmd_issue_i),
    .mode_i(port_mode_i),
    .address_i(command_address),
    .data_high_i(command_data_high),
    .data_low_i(command_data_low),
    .codec_select_field_i(codec_select_field_i),
    .tx_address_o(tx_address_o),
    .tx_data_o(tx_data_o),
    .tx_codec_id_o(tx_codec_id_o)
  );

  // --------------------------------------------------------------------------
  // Incoming status
  // --------------------------------------------------------------------------
  csc_rx_capture u_rx_capture
  (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .frame_start_i(rx_frame_start_i),
    .addr_stb_i(rx_addr_stb_i),
    .rx_addr_i(rx_addr_i),
    .data_stb_i(rx_data_stb_i),
    .rx_data_i(rx_data_i),
    .shadow_addr_o(shadow_addr),
    .shadow_data_o(shadow_data),
    .shadow_full_o(shadow_full)
  );

  // --------------------------------------------------------------------------
  // Transaction sequencing
  // --------------------------------------------------------------------------
  // The read result is taken only at the end of a response frame in which both
  // the returned address and the returned data arrived.
  assign commit = (state == CSC_ST_READ_WAIT) && rx_frame_end_i && shadow_full;

  always_comb
  begin
    next_state = state;
    next_txn_is_read = txn_is_read;
    next_txn_ac97 = txn_ac97;
    next_read_done = 1'b0;
    case (state)
      CSC_ST_IDLE:
      begin
        if (cmd_issue_i)
        begin
          next_txn_is_read = command_address[CSC_RW_BIT];
          next_txn_ac97 = csc_is_ac97(port_mode_i);
          if (command_address[CSC_RW_BIT])
          begin
            next_state = CSC_ST_READ_WAIT;
          end
          else
          begin
            next_state = CSC_ST_WRITE;
          end
        end
      end
      CSC_ST_WRITE:
      begin
        if (tx_frame_end_i)
        begin
          next_state = CSC_ST_IDLE;
        end
      end
      CSC_ST_READ_WAIT:
      begin
        if (commit)
        begin
          next_state = CSC_ST_IDLE;
          next_read_done = 1'b1;
        end
      end
      default:
      begin
        next_state = CSC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      state <= CSC_ST_IDLE;
      txn_is_read <= 1'b0;
      txn_ac97 <= 1'b0;
      read_done_o <= 1'b0;
    end
    else
    begin
      state <= next_state;
      txn_is_read <= next_txn_is_read;
      txn_ac97 <= next_txn_ac97;
      read_done_o <= next_read_done;
    end
  end

  assign busy_o = (state != CSC_ST_IDLE);
  assign tx_is_read_o = busy_o && txn_is_read;

  // --------------------------------------------------------------------------
  // Register writes and hardware updates
  // --------------------------------------------------------------------------
  assign hit_slot = (reg_addr_i == CSC_OFF_VALID_SLOT_LOW);
  assign hit_high = (reg_addr_i == CSC_OFF_COMMAND_DATA_HIGH);
  assign hit_low = (reg_addr_i == CSC_OFF_COMMAND_DATA_LOW);
  assign hit_addr = (reg_addr_i == CSC_OFF_COMMAND_ADDRESS);

  always_comb
  begin
    next_slot_flags = slot_flags;
    next_command_data_high = command_data_high;
    next_command_data_low = command_data_low;
    next_command_address = command_address;
    if (reg_wr_i)
    begin
      if (hit_slot)
      begin
        // The reserved low bits of the write data are dropped.
        next_slot_flags = reg_wdata_i[CSC_SLOT_FLAG_MSB:CSC_SLOT_FLAG_LSB];
      end
      if (hit_high)
      begin
        next_command_data_high = reg_wdata_i;
      end
      if (hit_low)
      begin
        next_command_data_low = reg_wdata_i;
      end
      if (hit_addr)
      begin
        next_command_address = reg_wdata_i;
      end
    end
    // A returned read result wins over a software write in the same cycle.
    if (commit)
    begin
      if (txn_ac97)
      begin
        // The select bit stays; only the seven address bits are replaced.
        next_command_address[CSC_AC97_ADDR_MSB:0] = shadow_addr[CSC_AC97_ADDR_MSB:0];
        next_command_data_high = shadow_data[15:8];
      end
      else
      begin
        next_command_address = shadow_addr;
      end
      // Outside AC '97 the high byte is left untouched.
      next_command_data_low = shadow_data[7:0];
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      slot_flags <= CSC_RST_VALID_SLOT_LOW[CSC_SLOT_FLAG_MSB:CSC_SLOT_FLAG_LSB];
      command_data_high <= CSC_RST_COMMAND_DATA_HIGH;
      command_data_low <= CSC_RST_COMMAND_DATA_LOW;
      command_address <= CSC_RST_COMMAND_ADDRESS;
    end
    else
    begin
      slot_flags <= next_slot_flags;
      command_data_high <= next_command_data_high;
      command_data_low <= next_command_data_low;
      command_address <= next_command_address;
    end
  end

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  always_comb
  begin
    next_reg_rdata = 8'h00;
    if (reg_rd_i)
    begin
      if (hit_slot)
      begin
        next_reg_rdata = {slot_flags, CSC_RESERVED_READ};
      end
      else if (hit_high)
      begin
        next_reg_rdata = command_data_high;
      end
      else if (hit_low)
      begin
        next_reg_rdata = command_data_low;
      end
      else if (hit_addr)
      begin
        next_reg_rdata = command_address;
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      reg_rdata_o <= 8'h00;
    end
    else
    begin
      reg_rdata_o <= next_reg_rdata;
    end
  end

  // --------------------------------------------------------------------------
  // Slot valid flags
  // --------------------------------------------------------------------------
  // Flag bit 4 of the output is slot 8, bit 0 is slot 12.
  assign slot_valid_flags_o = csc_is_ac97(port_mode_i) ? slot_flags : 5'h00;

endmodule
`default_nettype wire

// [hdl/csc_rx_capture.sv]
// Purpose: Collects the codec's returned address and status data over one frame.
// Assumes: Strobes come from the frame deserializer on the same clock.
// Notes: The seen flags are cleared at each frame start; the captured address and data keep their values.
`timescale 1ns/1ps
`default_nettype none
module csc_rx_capture
(
  input wire logic sys_clk_i, // System clock.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic frame_start_i, // Start of an incoming frame.
  input wire logic addr_stb_i, // Returned address is on rx_addr_i.
  input wire logic [7:0] rx_addr_i, // Returned register address.
  input wire logic data_stb_i, // Returned data is on rx_data_i.
  input wire logic [15:0] rx_data_i, // Returned status data.
  output logic [7:0] shadow_addr_o, // Captured address.
  output logic [15:0] shadow_data_o, // Captured status data.
  output logic shadow_full_o // Both address and data captured this frame.
);

  logic [7:0] next_shadow_addr;
  logic [15:0] next_shadow_data;
  logic addr_seen;
  logic data_seen;
  logic next_addr_seen;
  logic next_data_seen;

  // --------------------------------------------------------------------------
  // Capture
  // --------------------------------------------------------------------------
  always_comb
  begin
    next_shadow_addr = shadow_addr_o;
    next_shadow_data = shadow_data_o;
    next_addr_seen = addr_seen;
    next_data_seen = data_seen;
    if (frame_start_i)
    begin
      next_addr_seen = 1'b0;
      next_data_seen = 1'b0;
    end
    if (addr_stb_i)
    begin
      next_shadow_addr = rx_addr_i;
      next_addr_seen = 1'b1;
    end
    if (data_stb_i)
    begin
      next_shadow_data = rx_data_i;
      next_data_seen = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      shadow_addr_o <= 8'h00;
      shadow_data_o <= 16'h0000;
      addr_seen <= 1'b0;
      data_seen <= 1'b0;
    end
    else
    begin
      shadow_addr_o <= next_shadow_addr;
      shadow_data_o <= next_shadow_data;
      addr_seen <= next_addr_seen;
      data_seen <= next_data_seen;
    end
  end

  assign shadow_full_o = addr_seen && data_seen;

endmodule
`default_nettype wire

// [hdl/csc_tx_format.sv]
// Purpose: Latches and formats the outgoing secondary command for one frame.
// Assumes: load_i is a one-cycle pulse from the frame serializer.
// Notes: Values stay stable for the whole frame even if software rewrites registers.
`timescale 1ns/1ps
`default_nettype none
module csc_tx_format
  import csc_pkg::*;
(
  input wire logic sys_clk_i, // System clock.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic load_i, // Serializer takes the command now.
  input wire csc_pkg::csc_mode_type mode_i, // Port mode.
  input wire logic [7:0] address_i, // Command address register.
  input wire logic [7:0] data_high_i, // Command data high byte.
  input wire logic [7:0] data_low_i, // Command data low byte.
  input wire logic [1:0] codec_select_field_i, // Target codec identifier.
  output logic [7:0] tx_address_o, // Address word for the command slot.
  output logic [15:0] tx_data_o, // Data word for the data slot.
  output logic [1:0] tx_codec_id_o // Codec identifier sent with the command.
);

  logic [7:0] next_tx_address;
  logic [15:0] next_tx_data;
  logic [1:0] next_tx_codec_id;

  // --------------------------------------------------------------------------
  // Formatting
  // --------------------------------------------------------------------------
  always_comb
  begin
    next_tx_address = tx_address_o;
    next_tx_data = tx_data_o;
    next_tx_codec_id = tx_codec_id_o;
    if (load_i)
    begin
      next_tx_address = address_i;
      if (csc_is_ac97(mode_i))
      begin
        next_tx_data = {data_high_i, data_low_i};
        next_tx_codec_id = codec_select_field_i;
      end
      else
      begin
        // Only the low byte travels outside the AC '97 modes.
        next_tx_data = {8'h00, data_low_i};
        next_tx_codec_id = CSC_CID_PRIMARY;
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      tx_address_o <= 8'h00;
      tx_data_o <= 16'h0000;
      tx_codec_id_o <= 2'h0;
    end
    else
    begin
      tx_address_o <= next_tx_address;
      tx_data_o <= next_tx_data;
      tx_codec_id_o <= next_tx_codec_id;
    end
  end

endmodule
`default_nettype wire

// [sim/csc_codec_model.sv]
// Purpose: Behavioural far-side codec and frame engine for csc_regs.
// Assumes: Answers each transaction once busy is seen.
// Notes: Released data lines show the inverse of the last value.
`timescale 1ns/1ps
`default_nettype none
module csc_codec_model
(
  input wire logic sys_clk_i, // Clock.
  input wire logic busy_i, // Transaction in flight.
  input wire logic is_read_i, // Transaction is a read.
  input wire logic slow_i, // Answer late.
  input wire logic drop_i, // Leave out the status data.
  input wire logic [7:0] reply_addr_i, // Address to return.
  input wire logic [15:0] reply_data_i, // Status to return.
  output var logic tx_end_o, // Outgoing frame sent.
  output var logic start_o, // Incoming frame begins.
  output var logic astb_o, // Returned address valid.
  output var logic [7:0] addr_o, // Returned address.
  output var logic dstb_o, // Returned status valid.
  output var logic [15:0] data_o, // Returned status.
  output var logic end_o // Incoming frame done.
);
  initial
  begin
    {tx_end_o, start_o, astb_o, dstb_o, end_o, addr_o, data_o} = '0;
    forever
    begin
      @(posedge sys_clk_i);
      if (busy_i === 1'b1)
      begin
        repeat (slow_i ? 8 : 1) @(posedge sys_clk_i);
        if (is_read_i === 1'b1)
        begin
          start_o <= 1'b1;
          @(posedge sys_clk_i);
          start_o <= 1'b0;
          astb_o <= 1'b1;
          addr_o <= reply_addr_i;
          @(posedge sys_clk_i);
          astb_o <= 1'b0;
          addr_o <= ~reply_addr_i;
          dstb_o <= !drop_i;
          data_o <= reply_data_i;
          @(posedge sys_clk_i);
          dstb_o <= 1'b0;
          data_o <= ~reply_data_i;
          end_o <= 1'b1;
        end
        else
          tx_end_o <= 1'b1;
        @(posedge sys_clk_i);
        end_o <= 1'b0;
        tx_end_o <= 1'b0;
        while (busy_i === 1'b1) @(posedge sys_clk_i);
      end
    end
  end
endmodule
`default_nettype wire

// [sim/csc_regs_checker.sv]
// Purpose: Port-level assertions for the codec secondary command registers.
// Assumes: One clock domain; reset is synchronous and active high.
// Notes: Attached to every csc_regs instance by the bind below the module.
`timescale 1ns/1ps
`default_nettype none
module csc_regs_checker
  import csc_pkg::*;
(
  input wire logic sys_clk_i, // Clock.
  input wire logic rst_i, // Reset.
  input wire logic [15:0] reg_addr_i, // Register address.
  input wire logic reg_rd_i, // Read strobe.
  input wire logic [7:0] reg_rdata_o, // Read data.
  input wire csc_pkg::csc_mode_type port_mode_i, // Port mode.
  input wire logic cmd_issue_i, // Command taken.
  input wire logic tx_frame_end_i, // Outgoing frame sent.
  input wire logic rx_frame_end_i, // Incoming frame received.
  input wire logic [7:0] tx_address_o, // Command address.
  input wire logic [15:0] tx_data_o, // Command data.
  input wire logic [1:0] tx_codec_id_o, // Codec identifier.
  input wire logic tx_is_read_o, // Read in flight.
  input wire logic [4:0] slot_valid_flags_o, // Slot flags.
  input wire logic busy_o, // Transaction in flight.
  input wire logic read_done_o // Read committed.
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  a_reserved_zero: assert property ($past(reg_rd_i) && $past(reg_addr_i) == 16'hffd8
    |-> reg_rdata_o[2:0] == 3'h0) else $error("reserved slot bits not zero");
  a_unmapped_zero: assert property ($past(reg_rd_i) && ($past(reg_addr_i) < 16'hffd8
    || $past(reg_addr_i) > 16'hffdb) |-> reg_rdata_o == 8'h00) else $error("unmapped read");
  a_flags_gated: assert property (!(port_mode_i inside {CSC_MODE_AC97, CSC_MODE_AC97_DUAL})
    |-> slot_valid_flags_o == 5'h00) else $error("slot flags outside ac97 modes");
  a_high_masked: assert property ($past(cmd_issue_i) && !($past(port_mode_i) inside
    {CSC_MODE_AC97, CSC_MODE_AC97_DUAL}) |-> tx_data_o[15:8] == 8'h00 && tx_codec_id_o == 2'h0)
    else $error("high byte or codec id leaked");
  a_issue_busy: assert property (cmd_issue_i && !busy_o |=> busy_o
    && tx_is_read_o == tx_address_o[7]) else $error("transaction start wrong");
  a_write_ends: assert property (busy_o && !tx_is_read_o && tx_frame_end_i |=> !busy_o)
    else $error("write did not end");
  a_done_cause: assert property ($rose(read_done_o) |-> $past(rx_frame_end_i)
    && $past(tx_is_read_o)) else $error("read done without frame end");
  a_done_pulse: assert property (read_done_o |-> !busy_o ##1 !read_done_o)
    else $error("read done not a single pulse");
  a_tx_hold: assert property (!cmd_issue_i |=> $stable(tx_address_o) && $stable(tx_data_o))
    else $error("tx word changed without issue");
endmodule

bind csc_regs csc_regs_checker i_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .port_mode_i(port_mode_i), .cmd_issue_i(cmd_issue_i), .tx_frame_end_i(tx_frame_end_i),
  .rx_frame_end_i(rx_frame_end_i), .tx_address_o(tx_address_o), .tx_data_o(tx_data_o),
  .tx_codec_id_o(tx_codec_id_o), .tx_is_read_o(tx_is_read_o),
  .slot_valid_flags_o(slot_valid_flags_o), .busy_o(busy_o), .read_done_o(read_done_o));
`default_nettype wire

// [sim/test_csc_regs.sv]
// Purpose: Self-checking bench for csc_regs.
// Assumes: Register reads are checked from a queue by a monitor process.
// Notes: Random values come from an 8-bit shift register seeded at 56.
`timescale 1ns/1ps
`default_nettype none
module test_csc_regs;
  import csc_pkg::*;
  logic sys_clk_i, rst_i, reg_wr_i, reg_rd_i, cmd_issue_i, slow, drop, tx_end, rx_start;
  logic rx_astb, rx_dstb, rx_end, tx_is_read_o, busy_o, read_done_o;
  logic rd_d = 1'b0;
  logic [15:0] reg_addr_i, tx_data_o, rep_d, rx_data;
  logic [7:0] reg_wdata_i, reg_rdata_o, tx_address_o, rep_a, rx_addr, seed;
  logic [4:0] slot_valid_flags_o;
  logic [1:0] codec_select_field_i, tx_codec_id_o;
  csc_mode_type port_mode_i;
  logic [15:0] exp_q[$];
  int n_fail = 0;
  int checked = 0;

  csc_regs i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .port_mode_i(port_mode_i),
    .codec_select_field_i(codec_select_field_i), .cmd_issue_i(cmd_issue_i),
    .tx_frame_end_i(tx_end), .rx_frame_start_i(rx_start), .rx_addr_stb_i(rx_astb),
    .rx_addr_i(rx_addr), .rx_data_stb_i(rx_dstb), .rx_data_i(rx_data),
    .rx_frame_end_i(rx_end), .tx_address_o(tx_address_o), .tx_data_o(tx_data_o),
    .tx_codec_id_o(tx_codec_id_o), .tx_is_read_o(tx_is_read_o),
    .slot_valid_flags_o(slot_valid_flags_o), .busy_o(busy_o), .read_done_o(read_done_o));

  csc_codec_model i_codec (.sys_clk_i(sys_clk_i), .busy_i(busy_o), .is_read_i(tx_is_read_o),
    .slow_i(slow), .drop_i(drop), .reply_addr_i(rep_a), .reply_data_i(rep_d),
    .tx_end_o(tx_end), .start_o(rx_start), .astb_o(rx_astb), .addr_o(rx_addr),
    .dstb_o(rx_dstb), .data_o(rx_data), .end_o(rx_end));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic bus(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d);
    reg_wr_i <= w;
    reg_rd_i <= r;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
    bus(1'b0, 1'b0, a, d);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    exp_q.push_back(16'(e));
    bus(1'b0, 1'b1, a, 8'h00);
    bus(1'b0, 1'b0, a, 8'h00);
  endtask

  task automatic issue();
    cmd_issue_i <= 1'b1;
    @(posedge sys_clk_i);
    cmd_issue_i <= 1'b0;
    // The latched words are read at the next edge, before that edge updates anything.
    @(posedge sys_clk_i);
  endtask

  task automatic txn(input int m, input logic r);
    logic ac;
    logic [7:0] adr, dh, dl;
    ac = m < 2;
    seed = lfsr(seed);
    adr = (m == 3) ? {r, 3'h0, seed[3:0]} : {r, seed[6:0]};
    seed = lfsr(seed);
    dh = seed;
    seed = lfsr(seed);
    dl = seed;
    port_mode_i <= csc_mode_type'(m);
    codec_select_field_i <= 2'(m + r);
    slow <= r & m[0];
    rep_a <= ~adr;
    rep_d <= {dl, dh};
    wr(16'hffdb, adr);
    wr(16'hffd9, dh);
    wr(16'hffda, dl);
    issue();
    check("tx_address_o", 16'(adr), 16'(tx_address_o));
    check("tx_data_o", ac ? {dh, dl} : {8'h00, dl}, tx_data_o);
    check("tx_codec_id_o", ac ? 16'(2'(m + r)) : 16'h0000, 16'(tx_codec_id_o));
    check("tx_is_read_o", 16'(r), 16'(tx_is_read_o));
    if (r)
    begin
      rd(16'hffdb, adr);
      for (int i = 0; i < 40 && read_done_o !== 1'b1; i++) @(posedge sys_clk_i);
      check("read_done_o", 16'h0001, 16'(read_done_o));
      rd(16'hffdb, ac ? {adr[7], ~adr[6:0]} : ~adr);
      rd(16'hffda, dh);
      rd(16'hffd9, ac ? dl : dh);
    end
    else
    begin
      for (int i = 0; i < 40 && busy_o === 1'b1; i++) @(posedge sys_clk_i);
      check("busy_o", 16'h0000, 16'(busy_o));
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i)
  begin
    if (rd_d)
      check("reg_rdata_o", exp_q.pop_front(), 16'(reg_rdata_o));
    rd_d <= reg_rd_i;
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    n_fail++;
    finish_test();
  end

  initial
  begin
    {rst_i, reg_wr_i, reg_rd_i, cmd_issue_i, slow, drop} <= 6'h01 << 5;
    {reg_addr_i, reg_wdata_i, codec_select_field_i, rep_a, rep_d} <= '0;
    port_mode_i <= CSC_MODE_AC97;
    seed = 8'h38;
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    for (int a = 16'hffd7; a <= 16'hffdc; a++) rd(16'(a), 8'h00);
    $display("test reset_values done");
    for (int a = 16'hffd7; a <= 16'hffdc; a++)
    begin
      seed = lfsr(seed);
      wr(16'(a), seed);
      rd(16'(a), (a == 16'hffd8) ? seed & 8'hf8 : ((a > 16'hffd8 && a < 16'hffdc) ? seed : 8'h00));
    end
    $display("test register_access done");
    for (int m = 0; m < 5; m++)
    begin
      port_mode_i <= csc_mode_type'(m);
      seed = lfsr(seed);
      wr(16'hffd8, seed);
      check("slot_valid_flags_o", (m < 2) ? 16'(seed[7:3]) : 16'h0000, 16'(slot_valid_flags_o));
    end
    $display("test slot_flags done");
    for (int m = 0; m < 5; m++)
      for (int r = 0; r < 2; r++) txn(m, 1'(r));
    $display("test transactions done");
    drop <= 1'b1;
    port_mode_i <= CSC_MODE_AC97;
    wr(16'hffdb, 8'h81);
    issue();
    repeat (30) @(posedge sys_clk_i);
    check("busy_o", 16'h0001, 16'(busy_o));
    rd(16'hffdb, 8'h81);
    rst_i <= 1'b1;
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    drop <= 1'b0;
    rd(16'hffdb, 8'h00);
    rd(16'hffd8, 8'h00);
    check("busy_o", 16'h0000, 16'(busy_o));
    check("tx_address_o", 16'h0000, 16'(tx_address_o));
    $display("test incomplete_read done");
    finish_test();
  end
endmodule
`default_nettype wire
